/* shared/rtca_map.svh */
// register offsets, field positions, reset values and timing counts of the rtc auxiliary timers
`ifndef RTCA_MAP_SVH
`define RTCA_MAP_SVH
`define RTCA_ADR_OUTCTL 5'h08
`define RTCA_ADR_WDOG 5'h09
`define RTCA_ADR_A1MON 5'h0a
`define RTCA_ADR_FLAGS 5'h0f
`define RTCA_ADR_TVAL 5'h10
`define RTCA_ADR_TCTL 5'h11
`define RTCA_ADR_A2RATE 5'h13
`define RTCA_ADR_A2FIRST 5'h14
`define RTCA_ADR_A2LAST 5'h18
`define RTCA_RST_OUTCTL 8'h80
`define RTCA_RST_WDOG 8'h00
`define RTCA_RST_A1MON 8'h40
`define RTCA_RST_TCTL 8'h03
`define RTCA_RST_A2RATE 8'h10
`define RTCA_BIT_OUT 7
`define RTCA_BIT_FT 6
`define RTCA_BIT_OFIE 7
`define RTCA_BIT_ALARM1_IRQ_ENABLE 7
`define RTCA_BIT_WAVE_OUTPUT_ENABLE 6
`define RTCA_BIT_TE 7
`define RTCA_BIT_TPM 6
`define RTCA_BIT_TIE 5
`define RTCA_BIT_SECOND_ALARM_ENABLE 1
`define RTCA_BIT_RPT 7
`define RTCA_BIT_REPEAT_BIT_4 6
`define RTCA_OSC_HZ 32768
`define RTCA_PULSE_N1_4K_DEN 8192
`define RTCA_PULSE_NX_4K_DEN 4096
`define RTCA_PULSE_N1_64_DEN 128
`define RTCA_PULSE_SLOW_DEN 64
`define RTCA_PW_N1_4K (`RTCA_OSC_HZ / `RTCA_PULSE_N1_4K_DEN)
`define RTCA_PW_NX_4K (`RTCA_OSC_HZ / `RTCA_PULSE_NX_4K_DEN)
`define RTCA_PW_N1_64 (`RTCA_OSC_HZ / `RTCA_PULSE_N1_64_DEN)
`define RTCA_PW_SLOW (`RTCA_OSC_HZ / `RTCA_PULSE_SLOW_DEN)
`define RTCA_SEC_PER_MIN 6'd59
`define RTCA_SEC_PER_4S 2'd3
`define RTCA_FT_DIV_BIT 5
`endif

/* shared/rtca_pkg.sv */
// types shared by the rtc auxiliary timer block
package rtca_pkg;
  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } rtca_time_t;
  typedef enum logic [2:0] {
    RTCA_RPT_SEC = 3'b000,
    RTCA_RPT_MIN = 3'b001,
    RTCA_RPT_HOUR = 3'b010,
    RTCA_RPT_DAY = 3'b011,
    RTCA_RPT_MONTH = 3'b100,
    RTCA_RPT_YEAR = 3'b101
  } rtca_rpt_t;
  typedef enum logic [1:0] {
    RTCA_PIN_RELEASE = 2'b00,
    RTCA_PIN_LOW = 2'b01,
    RTCA_PIN_WAVE = 2'b10
  } rtca_pin_t;
endpackage : rtca_pkg

/* logic/rtca_aux_timers.sv */
// second alarm, watchdog, countdown timer, square wave and shared interrupt pin of the rtc
`timescale 1ns/1ps
`include "rtca_map.svh"
module rtca_aux_timers
  import rtca_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // register port from the serial front end
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // time-keeping core
  input wire rtca_time_t time_i,
  input wire logic sec_tick_i,
  input wire logic alarm1_event_i,
  // pins and analog monitors
  input wire logic osc_clk_i,
  input wire logic power_fail_i,
  input wire logic battery_low_flag_i,
  input wire logic osc_fail_flag_i,
  output logic wave_pin_o,
  output logic shared_irq_pin_o,
  output logic shared_irq_pin_oe_o
);
  // pin synchronisers: osc, power fail, battery low, osc fail
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic osc_d_r;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      osc_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_s1_r <= {osc_fail_flag_i, battery_low_flag_i, power_fail_i, osc_clk_i};
      pin_s2_r <= pin_s1_r;
      osc_d_r <= pin_s2_r[0];
    end
  end
  logic osc_tick;
  logic pf_s;
  assign osc_tick = pin_s2_r[0] & ~osc_d_r;
  assign pf_s = pin_s2_r[1];

  // divider chain from the 32.768 kHz oscillator
  logic [14:0] div_r;
  logic [5:0] min_cnt_r;
  logic [1:0] four_cnt_r;
  logic t4096, t64, t16, t4hz, t1, t60, t4s;
  assign t4096 = osc_tick & (&div_r[2:0]);
  assign t64 = osc_tick & (&div_r[8:0]);
  assign t16 = osc_tick & (&div_r[10:0]);
  assign t4hz = osc_tick & (&div_r[12:0]);
  assign t1 = osc_tick & (&div_r[14:0]);
  assign t60 = t1 & (min_cnt_r == `RTCA_SEC_PER_MIN);
  assign t4s = t1 & (four_cnt_r == `RTCA_SEC_PER_4S);
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      div_r <= 15'h0000;
      min_cnt_r <= 6'h00;
      four_cnt_r <= 2'h0;
    end
    else if (ce_i && osc_tick)
    begin
      div_r <= div_r + 15'h0001;
      if (t1)
      begin
        min_cnt_r <= t60 ? 6'h00 : min_cnt_r + 6'h01;
        four_cnt_r <= four_cnt_r + 2'h1;
      end
    end
  end

  // registers
  logic [7:0] outctl_r, wdog_r, a1mon_r, tval_r, tcnt_r, tctl_r, a2rate_r;
  logic [7:0] a2_r [0:4];
  logic wr_hit, rd_flags, wr_wdog, wr_tval;
  assign wr_hit = ce_i & reg_wr_i;
  assign rd_flags = ce_i & reg_rd_i & (reg_addr_i == `RTCA_ADR_FLAGS);
  assign wr_wdog = wr_hit & (reg_addr_i == `RTCA_ADR_WDOG);
  assign wr_tval = wr_hit & (reg_addr_i == `RTCA_ADR_TVAL);
  logic wave_output_enable, te, tpm, countdown_irq_enable, second_alarm_enable, alarm1_irq_enable, ofie, out_bit, ft_bit;
  logic [1:0] tsel;
  logic [3:0] rate;
  logic [4:0] wd_mult;
  logic [1:0] wd_res;
  assign wave_output_enable = a1mon_r[`RTCA_BIT_WAVE_OUTPUT_ENABLE];
  assign alarm1_irq_enable = a1mon_r[`RTCA_BIT_ALARM1_IRQ_ENABLE];
  assign te = tctl_r[`RTCA_BIT_TE];
  assign tpm = tctl_r[`RTCA_BIT_TPM];
  assign countdown_irq_enable = tctl_r[`RTCA_BIT_TIE];
  assign tsel = tctl_r[1:0];
  assign second_alarm_enable = a2rate_r[`RTCA_BIT_SECOND_ALARM_ENABLE];
  assign rate = a2rate_r[7:4];
  assign ofie = wdog_r[`RTCA_BIT_OFIE];
  assign wd_mult = wdog_r[6:2];
  assign wd_res = wdog_r[1:0];
  assign out_bit = outctl_r[`RTCA_BIT_OUT];
  assign ft_bit = outctl_r[`RTCA_BIT_FT];

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      outctl_r <= `RTCA_RST_OUTCTL;
      wdog_r <= `RTCA_RST_WDOG;
      a1mon_r <= `RTCA_RST_A1MON;
      a2rate_r <= `RTCA_RST_A2RATE;
      for (int i = 0; i < 5; i++)
        a2_r[i] <= 8'h00;
    end
    else if (wr_hit)
    begin
      if (reg_addr_i == `RTCA_ADR_OUTCTL)
        outctl_r <= reg_wdata_i;
      else if (reg_addr_i == `RTCA_ADR_WDOG)
        wdog_r <= reg_wdata_i;
      else if (reg_addr_i == `RTCA_ADR_A1MON)
        a1mon_r <= reg_wdata_i;
      else if (reg_addr_i == `RTCA_ADR_A2RATE)
        a2rate_r <= {reg_wdata_i[7:4], 2'b00, reg_wdata_i[1], 1'b0};
      else if (reg_addr_i >= `RTCA_ADR_A2FIRST && reg_addr_i <= `RTCA_ADR_A2LAST)
        a2_r[3'(reg_addr_i - `RTCA_ADR_A2FIRST)] <= reg_wdata_i;
    end
  end

  // countdown control: power-down drops the enable, other bits kept
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      tctl_r <= `RTCA_RST_TCTL;
    else if (ce_i)
    begin
      if (pf_s)
        tctl_r[`RTCA_BIT_TE] <= 1'b0;
      else if (wr_hit && reg_addr_i == `RTCA_ADR_TCTL)
        tctl_r <= {reg_wdata_i[7:5], 3'b000, reg_wdata_i[1:0]};
    end
  end

  // countdown timer
  logic src_tick, run, tc_end;
  always_comb
  begin
    case (tsel)
      2'b00: src_tick = t4096;
      2'b01: src_tick = t64;
      2'b10: src_tick = t1;
      default: src_tick = t60;
    endcase
  end
  assign run = te & (tval_r != 8'h00);
  assign tc_end = ce_i & src_tick & run & (tcnt_r == 8'h01);
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      tval_r <= 8'h00;
      tcnt_r <= 8'h00;
    end
    else if (wr_tval)
    begin
      tval_r <= reg_wdata_i;
      tcnt_r <= reg_wdata_i;
    end
    else if (ce_i && src_tick && run)
      tcnt_r <= (tcnt_r == 8'h01) ? tval_r : tcnt_r - 8'h01;
  end

  // pulse-mode width in oscillator ticks
  logic [9:0] pulse_cnt_r;
  logic [9:0] pulse_w;
  logic pulse_gate;
  assign pulse_gate = te & countdown_irq_enable & tpm;
  always_comb
  begin
    if (tsel == 2'b00)
      pulse_w = (tval_r == 8'h01) ? 10'(`RTCA_PW_N1_4K) : 10'(`RTCA_PW_NX_4K);
    else if (tsel == 2'b01)
      pulse_w = (tval_r == 8'h01) ? 10'(`RTCA_PW_N1_64) : 10'(`RTCA_PW_SLOW);
    else
      pulse_w = 10'(`RTCA_PW_SLOW);
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      pulse_cnt_r <= 10'h000;
    else if (ce_i)
    begin
      if (!pulse_gate)
        pulse_cnt_r <= 10'h000;
      else if (tc_end)
        pulse_cnt_r <= pulse_w;
      else if (osc_tick && pulse_cnt_r != 10'h000)
        pulse_cnt_r <= pulse_cnt_r - 10'h001;
    end
  end

  // watchdog
  logic [4:0] wd_cnt_r;
  logic wd_irq_r, wd_tick, wd_expire;
  always_comb
  begin
    case (wd_res)
      2'b00: wd_tick = t16;
      2'b01: wd_tick = t4hz;
      2'b10: wd_tick = t1;
      default: wd_tick = t4s;
    endcase
  end
  assign wd_expire = ce_i & ~wr_wdog & wd_tick & ~wd_irq_r & (wd_mult != 5'h00)
    & (wd_cnt_r + 5'h01 == wd_mult);
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      wd_cnt_r <= 5'h00;
      wd_irq_r <= 1'b0;
    end
    else if (wr_wdog)
    begin
      wd_cnt_r <= 5'h00;
      if (reg_wdata_i[6:0] == 7'h00)
        wd_irq_r <= 1'b0;
    end
    else if (wd_expire)
    begin
      wd_irq_r <= 1'b1;
      wd_cnt_r <= 5'h00;
    end
    else if (ce_i && wd_tick && !wd_irq_r && wd_mult != 5'h00)
      wd_cnt_r <= wd_cnt_r + 5'h01;
  end

  // second alarm
  logic [4:0] rpt;
  rtca_rpt_t a2_mode;
  logic m_sec, m_min, m_hour, m_date, m_mon, a2_hit, a2_event;
  assign rpt = {a2_r[1][`RTCA_BIT_RPT], a2_r[1][`RTCA_BIT_REPEAT_BIT_4], a2_r[2][`RTCA_BIT_RPT],
    a2_r[3][`RTCA_BIT_RPT], a2_r[4][`RTCA_BIT_RPT]};
  always_comb
  begin
    case (rpt)
      5'b11110: a2_mode = RTCA_RPT_MIN;
      5'b11100: a2_mode = RTCA_RPT_HOUR;
      5'b11000: a2_mode = RTCA_RPT_DAY;
      5'b10000: a2_mode = RTCA_RPT_MONTH;
      5'b00000: a2_mode = RTCA_RPT_YEAR;
      default: a2_mode = RTCA_RPT_SEC;
    endcase
  end
  assign m_sec = a2_r[4][6:0] == time_i.second[6:0];
  assign m_min = a2_r[3][6:0] == time_i.minute[6:0];
  assign m_hour = a2_r[2][5:0] == time_i.hour[5:0];
  assign m_date = a2_r[1][5:0] == time_i.date[5:0];
  assign m_mon = a2_r[0][4:0] == time_i.month[4:0];
  always_comb
  begin
    case (a2_mode)
      RTCA_RPT_MIN: a2_hit = m_sec;
      RTCA_RPT_HOUR: a2_hit = m_sec & m_min;
      RTCA_RPT_DAY: a2_hit = m_sec & m_min & m_hour;
      RTCA_RPT_MONTH: a2_hit = m_sec & m_min & m_hour & m_date;
      RTCA_RPT_YEAR: a2_hit = m_sec & m_min & m_hour & m_date & m_mon;
      default: a2_hit = 1'b1;
    endcase
  end
  assign a2_event = ce_i & sec_tick_i & second_alarm_enable & a2_hit;

  // flags and alarm interrupt; a new event wins over the read that clears
  logic wdf_r, af1_r, af2_r, tf_r, alarm_irq_r;
  logic a1_event;
  assign a1_event = ce_i & alarm1_event_i;
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      wdf_r <= 1'b0;
      af1_r <= 1'b0;
      af2_r <= 1'b0;
      tf_r <= 1'b0;
      alarm_irq_r <= 1'b0;
    end
    else if (ce_i)
    begin
      wdf_r <= wd_expire | (wdf_r & ~rd_flags);
      af1_r <= a1_event | (af1_r & ~rd_flags);
      af2_r <= a2_event | (af2_r & ~rd_flags);
      tf_r <= tc_end | (tf_r & ~rd_flags);
      alarm_irq_r <= (alarm1_irq_enable & (a1_event | a2_event)) | (alarm_irq_r & ~rd_flags);
    end
  end

  // read port
  logic [7:0] rd_mux;
  always_comb
  begin
    if (reg_addr_i == `RTCA_ADR_OUTCTL)
      rd_mux = outctl_r;
    else if (reg_addr_i == `RTCA_ADR_WDOG)
      rd_mux = wdog_r;
    else if (reg_addr_i == `RTCA_ADR_A1MON)
      rd_mux = a1mon_r;
    else if (reg_addr_i == `RTCA_ADR_FLAGS)
      rd_mux = {wdf_r, af1_r, af2_r, pin_s2_r[2], tf_r, pin_s2_r[3], 2'b00};
    else if (reg_addr_i == `RTCA_ADR_TVAL)
      rd_mux = tcnt_r;
    else if (reg_addr_i == `RTCA_ADR_TCTL)
      rd_mux = tctl_r;
    else if (reg_addr_i == `RTCA_ADR_A2RATE)
      rd_mux = a2rate_r;
    else if (reg_addr_i >= `RTCA_ADR_A2FIRST && reg_addr_i <= `RTCA_ADR_A2LAST)
      rd_mux = a2_r[3'(reg_addr_i - `RTCA_ADR_A2FIRST)];
    else
      rd_mux = 8'h00;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else if (ce_i)
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

  // square wave: bit k of the divider runs at 32768 / 2^(k+1) Hz
  logic wave_nxt;
  always_comb
  begin
    if (!wave_output_enable || rate == 4'h0)
      wave_nxt = 1'b0;
    else if (rate == 4'h1)
      wave_nxt = pin_s2_r[0];
    else
      wave_nxt = div_r[4'(rate - 4'h1)];
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      wave_pin_o <= 1'b0;
    else if (ce_i)
      wave_pin_o <= wave_nxt;
  end

  // shared open-drain pin; level sources outrank the timer pulse and the test wave
  logic wd_armed, lvl_active, any_enabled, ft_on;
  rtca_pin_t pin_nxt;
  assign wd_armed = wd_mult != 5'h00;
  assign lvl_active = alarm_irq_r | wd_irq_r | (ofie & pin_s2_r[3])
    | (te & countdown_irq_enable & ~tpm & tf_r);
  assign any_enabled = alarm1_irq_enable | ofie | wd_armed | (te & countdown_irq_enable);
  assign ft_on = ft_bit & out_bit & ~(wd_armed & ~wave_output_enable);
  always_comb
  begin
    if (lvl_active)
      pin_nxt = RTCA_PIN_LOW;
    else if (pulse_gate && pulse_cnt_r != 10'h000)
      pin_nxt = RTCA_PIN_LOW;
    else if (any_enabled)
      pin_nxt = RTCA_PIN_RELEASE;
    else if (ft_on)
      pin_nxt = RTCA_PIN_WAVE;
    else
      pin_nxt = out_bit ? RTCA_PIN_RELEASE : RTCA_PIN_LOW;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
      shared_irq_pin_oe_o <= 1'b0;
    else if (ce_i)
    begin
      case (pin_nxt)
        RTCA_PIN_LOW: shared_irq_pin_oe_o <= 1'b1;
        RTCA_PIN_WAVE: shared_irq_pin_oe_o <= ~div_r[`RTCA_FT_DIV_BIT];
        default: shared_irq_pin_oe_o <= 1'b0;
      endcase
    end
  end
  // open drain: only ever drives low
  always_ff @(posedge ref_clk_i)
    shared_irq_pin_o <= 1'b0;

  // checks
  AST_TF_SET: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    tc_end |=> tf_r && tcnt_r == ($past(wr_tval) ? $past(reg_wdata_i) : $past(tval_r)))
    else $error("countdown end lost");
  AST_TF_HOLD_ON_WRITE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (tf_r && wr_tval && !rd_flags) |=> tf_r) else $error("value write cleared flag");
  AST_STOP_ZERO: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (tval_r == 8'h00 && !wr_tval) |=> $stable(tcnt_r)) else $error("counter ran with n 0");
  AST_WD_TIMEOUT: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wd_expire |=> wdf_r && wd_irq_r ##1 shared_irq_pin_oe_o) else $error("timeout missed");
  AST_WD_RELEASE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_wdog && reg_wdata_i == 8'h00) |=> !wd_irq_r && !wd_armed)
    else $error("00h did not release watchdog");
  AST_FLAGS_CLEAR: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (rd_flags && !wd_expire && !tc_end) |=> !wdf_r && !tf_r) else $error("read left flag");
  AST_PF_TE: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (ce_i && pf_s) |=> !te) else $error("power-down kept enable");
  AST_AL2_OFF: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !second_alarm_enable |-> !a2_event) else $error("second alarm fired while disabled");
  AST_LEVEL_PIN: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (ce_i && te && countdown_irq_enable && !tpm && tf_r) |=> shared_irq_pin_oe_o) else $error("level irq off");
  AST_WAVE_OFF: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (ce_i && !wave_output_enable) |=> !wave_pin_o) else $error("wave without enable");
  COV_TF: cover property (@(posedge ref_clk_i) disable iff (srst_i) tc_end ##1 rd_flags);
  COV_WD: cover property (@(posedge ref_clk_i) disable iff (srst_i) wd_expire);
  COV_A2: cover property (@(posedge ref_clk_i) disable iff (srst_i) a2_event && alarm1_irq_enable);
endmodule : rtca_aux_timers

/* testbench/rtca_host_model.sv */
// host-side register master and crystal stand-in for the auxiliary timers
`timescale 1ns/1ps
module rtca_host_model
(
  // clock
  input wire logic ref_clk_i,
  // register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [4:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  // crystal
  output logic osc_clk_o
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 5'h00;
    reg_wdata_o = 8'h00;
    osc_clk_o = 1'b0;
  end

  // odd half period keeps the crystal unrelated in phase to the system clock
  always #9 osc_clk_o = ~osc_clk_o;

  // any write to the watchdog register restarts the watchdog; 00h after a timeout frees the pin
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    // released data must not keep showing the last byte
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_o = 1'b0;
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hxx;
  endtask : rd
endmodule : rtca_host_model

/* testbench/rtca_aux_timers_tb.sv */
// self-checking bench of the rtc auxiliary timers
`timescale 1ns/1ps
module rtca_aux_timers_tb import rtca_pkg::*; ();
  logic clk = 1'b0;
  logic srst, ce, pf, bl, of, stk, a1;
  rtca_time_t tm;
  logic wr, rd, osc, rv, wave, irq, oe;
  logic [4:0] adr;
  logic [7:0] wd, rdat;
  int num_errors = 0;
  int checks_done = 0;
  int oc = 0;

  always #2 clk = ~clk;
  always @(posedge osc) oc++;

  rtca_aux_timers dut_u (.ref_clk_i(clk), .srst_i(srst), .ce_i(ce), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .time_i(tm), .sec_tick_i(stk), .alarm1_event_i(a1),
    .osc_clk_i(osc), .power_fail_i(pf), .battery_low_flag_i(bl),
    .osc_fail_flag_i(of), .wave_pin_o(wave), .shared_irq_pin_o(irq),
    .shared_irq_pin_oe_o(oe));

  rtca_host_model host_u (.ref_clk_i(clk), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(adr), .reg_wdata_o(wd), .reg_rdata_i(rdat), .reg_rvalid_i(rv),
    .osc_clk_o(osc));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check

  function automatic logic near(input int t, input int e);
    return (t >= e - 1) && (t <= e + 1);
  endfunction : near

  // bounded wait for a pin level; running out ends the run
  task automatic wait_oe(input logic v, input int lim);
    int i;
    i = 0;
    while (oe !== v)
    begin
      if (i == lim)
      begin
        num_errors++;
        $display("unexpected at %0t: pin wait timed out", $time);
        wrap_up();
      end
      i++;
      @(negedge clk);
    end
  endtask : wait_oe

  task automatic osc_wait(input int n);
    int s;
    s = oc;
    while (oc - s < n)
      @(negedge clk);
  endtask : osc_wait

  task automatic ticks_while(input logic v, output int t);
    int s;
    s = oc;
    while (oe === v && oc - s < 600)
      @(negedge clk);
    t = oc - s;
  endtask : ticks_while

  task automatic stay(input logic v, input int n, input string m);
    logic bad;
    bad = 1'b0;
    repeat (n) @(negedge clk) if (oe !== v) bad = 1'b1;
    check({7'h00, bad}, 8'h00, m);
  endtask : stay

  task automatic t_regs();
    logic [7:0] d;
    logic [4:0] a [7] = '{5'h08, 5'h09, 5'h0a, 5'h10, 5'h11, 5'h13, 5'h05};
    logic [7:0] e [7] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h03, 8'h10, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      host_u.rd(a[i], d);
      check(d, e[i], "reset value");
    end
    for (int i = 20; i < 25; i++)
    begin
      host_u.wr(5'(i), 8'(i) ^ 8'h5a);
      host_u.rd(5'(i), d);
      check(d, 8'(i) ^ 8'h5a, "user byte");
    end
    bl = 1'b1;
    repeat (4) @(negedge clk);
    host_u.rd(5'h0f, d);
    check(d & 8'h14, 8'h10, "battery low flag");
    bl = 1'b0;
    $display("done regs");
  endtask : t_regs

  task automatic t_level();
    logic [7:0] d, c1, c2;
    host_u.wr(5'h10, 8'h02);
    host_u.wr(5'h11, 8'ha0);
    wait_oe(1'b1, 400);
    host_u.wr(5'h10, 8'h02);
    check(8'(oe), 8'h01, "pin after value write");
    host_u.rd(5'h0f, d);
    check(d & 8'h08, 8'h08, "countdown flag");
    @(negedge clk);
    check(8'(oe), 8'h00, "pin after flags read");
    wait_oe(1'b1, 400);
    host_u.wr(5'h11, 8'h80);
    stay(1'b0, 20, "irq enable cleared");
    host_u.wr(5'h10, 8'h00);
    host_u.rd(5'h0f, d);
    osc_wait(64);
    host_u.rd(5'h0f, d);
    check(d & 8'h08, 8'h00, "stopped at zero");
    host_u.wr(5'h10, 8'h30);
    osc_wait(40);
    pf = 1'b1;
    repeat (4) @(negedge clk);
    pf = 1'b0;
    host_u.rd(5'h11, d);
    check(d & 8'h80, 8'h00, "enable after power-down");
    host_u.rd(5'h10, c1);
    osc_wait(40);
    host_u.rd(5'h10, c2);
    check(c2, c1, "held count");
    host_u.wr(5'h11, 8'h80);
    osc_wait(12);
    host_u.rd(5'h10, d);
    check({7'h00, d < c1 && c1 - d <= 8'h02}, 8'h01, "resumed count");
    host_u.wr(5'h11, 8'h03);
    $display("done level");
  endtask : t_level

  task automatic t_pulse();
    logic [7:0] d;
    int hi, lo;
    for (int n = 1; n <= 3; n += 2)
    begin
      host_u.wr(5'h10, 8'(n));
      host_u.wr(5'h11, 8'he0);
      wait_oe(1'b0, 400);
      wait_oe(1'b1, 400);
      wait_oe(1'b0, 400);
      wait_oe(1'b1, 400);
      ticks_while(1'b1, hi);
      ticks_while(1'b0, lo);
      check({7'h00, near(hi, n == 1 ? 4 : 8)}, 8'h01, "pulse width");
      check({7'h00, near(lo, n * 8 - (n == 1 ? 4 : 8))}, 8'h01, "spacing");
    end
    host_u.rd(5'h0f, d);
    wait_oe(1'b0, 400);
    wait_oe(1'b1, 400);
    check(8'(oe), 8'h01, "pulses after flag clear");
    of = 1'b1;
    host_u.wr(5'h09, 8'h80);
    repeat (4) @(negedge clk);
    stay(1'b1, 200, "held low in pulse mode");
    of = 1'b0;
    host_u.wr(5'h09, 8'h00);
    host_u.wr(5'h11, 8'hc0);
    stay(1'b0, 200, "pulses stopped");
    host_u.wr(5'h11, 8'h03);
    $display("done pulse");
  endtask : t_pulse

  task automatic t_wdog();
    logic [7:0] d;
    // two units of 1/16 s; the first unit may be partial
    host_u.wr(5'h09, 8'h08);
    osc_wait(1500);
    check(8'(oe), 8'h00, "watchdog early");
    host_u.wr(5'h09, 8'h08);
    osc_wait(1900);
    check(8'(oe), 8'h00, "watchdog after restart");
    wait_oe(1'b1, 11000);
    host_u.rd(5'h0f, d);
    check(d & 8'h80, 8'h80, "watchdog flag");
    host_u.rd(5'h0f, d);
    check(d & 8'h80, 8'h00, "watchdog flag cleared");
    check(8'(oe), 8'h01, "pin held");
    host_u.wr(5'h09, 8'h00);
    @(negedge clk);
    check(8'(oe), 8'h00, "pin freed");
    $display("done watchdog");
  endtask : t_wdog

  task automatic t_pin();
    host_u.wr(5'h0a, 8'h00);
    host_u.wr(5'h08, 8'hc0);
    host_u.wr(5'h09, 8'h7f);
    stay(1'b0, 400, "frequency test denied");
    host_u.wr(5'h09, 8'h00);
    wait_oe(1'b1, 400);
    check(8'(oe), 8'h01, "frequency test back");
    host_u.wr(5'h08, 8'h00);
    stay(1'b1, 50, "out bit low");
    host_u.wr(5'h08, 8'h80);
    stay(1'b0, 50, "out bit high");
    $display("done pin");
  endtask : t_pin

  task automatic t_wave();
    int e, s;
    logic p;
    logic [3:0] r [5] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h1};
    logic [7:0] q [5] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h00};
    int x [5] = '{64, 16, 8, 0, 0};
    for (int i = 0; i < 5; i++)
    begin
      host_u.wr(5'h0a, q[i]);
      host_u.wr(5'h13, {r[i], 4'h0});
      osc_wait(8);
      e = 0;
      s = oc;
      p = wave;
      while (oc - s < 64)
      begin
        @(negedge clk);
        if (wave === 1'b1 && p === 1'b0)
          e++;
        p = wave;
      end
      check({7'h00, near(e, x[i])}, 8'h01, "wave edges");
    end
    host_u.wr(5'h0a, 8'h40);
    $display("done wave");
  endtask : t_wave

  task automatic t_alarm();
    logic [7:0] d;
    logic [7:0] a5 [10] = '{8'hc1, 8'hc1, 8'hc1, 8'hc1, 8'hc1, 8'hc1, 8'h81, 8'h01,
      8'h41, 8'hc1};
    logic [7:0] a6 [10] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00,
      8'h80, 8'h80};
    logic [7:0] a7 [10] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h80, 8'h80};
    logic [7:0] a8 [10] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h80, 8'h80};
    logic [7:0] mn [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h01, 8'h01};
    logic [7:0] sc [10] = '{8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h05, 8'h05};
    logic ex [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    host_u.wr(5'h0a, 8'hc0);
    host_u.wr(5'h13, 8'h12);
    host_u.wr(5'h14, 8'h01);
    tm.month = 8'h01;
    tm.date = 8'h01;
    for (int i = 0; i < 10; i++)
    begin
      // last entry runs with the second alarm switched off
      if (i == 9)
        host_u.wr(5'h13, 8'h10);
      host_u.wr(5'h15, a5[i]);
      host_u.wr(5'h16, a6[i]);
      host_u.wr(5'h17, a7[i]);
      host_u.wr(5'h18, a8[i]);
      tm.minute = mn[i];
      tm.second = sc[i];
      @(negedge clk);
      stk = 1'b1;
      @(negedge clk);
      stk = 1'b0;
      repeat (3) @(negedge clk);
      check(8'(oe), 8'(ex[i]), "alarm pin");
      host_u.rd(5'h0f, d);
      check(d & 8'h20, {2'b00, ex[i], 5'h00}, "alarm flag");
      @(negedge clk);
      check(8'(oe), 8'h00, "alarm pin after read");
    end
    a1 = 1'b1;
    @(negedge clk);
    a1 = 1'b0;
    repeat (3) @(negedge clk);
    host_u.rd(5'h0f, d);
    check(d & 8'h40, 8'h40, "first alarm flag");
    host_u.wr(5'h0a, 8'h40);
    $display("done alarm");
  endtask : t_alarm

  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    pf = 1'b0;
    bl = 1'b0;
    of = 1'b0;
    stk = 1'b0;
    a1 = 1'b0;
    tm = '0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    t_regs();
    t_level();
    t_pulse();
    t_wdog();
    t_pin();
    t_wave();
    t_alarm();
    wrap_up();
  end
endmodule : rtca_aux_timers_tb
